// ==== inc/sac_pkg.sv ====
// Purpose: shared constants of the step attenuator control port (device end and host end)
// Assumes: aclk at 200 MHz on both ends; link clock made by the host
// Notes: host register offsets and fields are our own choice
// Function
// R1 - select low parallel, high serial path
// R2 - seven weighted bits, 0.25 to 16 dB
// R3 - latched parallel: capture on strobe pulse
// R4 - direct parallel: strobe high, follow bits
// R5 - 16-bit shift register, two 8-bit words
// R6 - apply word only on address match
// R7 - host shifts LSB first, attenuation word first
// R8 - shift while strobe low; rise transfers
// R9 - host holds strobe low during load
// R10 - host ties parallel bits low in serial
// R11 - serial/latched power-up: maximum until latched
// R12 - direct power-up: maximum, delay, then preset
// R13 - floating inputs in direct: minimum attenuation
// R14 - serial power-up: clear spare before parallel
// R15 - attenuation word first stages, address last
// R16 - parallel power-up: bits low until spare cleared
// R17 - sequencing once; then switch freely
// R18 - open parallel input reads low
// R19 - host lowers strobe before next word
`default_nettype none
package sac_pkg;
    localparam int SAC_ATT_W = 7;
    localparam int SAC_SR_W = 16;
    localparam int SAC_WORD_W = 8;
    localparam int SAC_ADDR_W = 3;
    localparam logic [6:0] SAC_ATT_MAX = 7'h7f;
    localparam logic [6:0] SAC_ATT_MIN = 7'h00;
    // timing
    localparam int SAC_CLK_MHZ = 200;
    localparam int SAC_PUP_DELAY_US = 400;
    localparam int SAC_PUP_CYCLES = SAC_PUP_DELAY_US * SAC_CLK_MHZ;
    localparam int SAC_SYNC_CYCLES = 3;
    localparam int SAC_LINK_HALF = 8;
    localparam int SAC_STROBE_HOLD = 16;
    // host register map, byte addresses
    localparam logic [7:0] SAC_REG_CTRL = 8'h00;
    localparam logic [7:0] SAC_REG_PAR = 8'h04;
    localparam logic [7:0] SAC_REG_SER = 8'h08;
    localparam logic [7:0] SAC_REG_STAT = 8'h0c;
    // ctrl fields
    localparam int SAC_CTRL_SEL = 0;
    localparam int SAC_CTRL_DIRECT = 1;
    localparam int SAC_CTRL_OE = 2;
    localparam logic [2:0] SAC_CTRL_RST = 3'h0;
    localparam logic [1:0] SAC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SAC_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ==== inc/sac_if.sv ====
// Purpose: control pins between host controller and step attenuator
// Assumes: host drives every pin; par_oe low models open parallel inputs
// Notes: serial_clk is the link clock, made by the host
`timescale 1ns/100ps
`default_nettype none
interface sac_if;
    logic interface_select;
    logic latch_strobe;
    logic [6:0] attenuation_bits;
    logic par_oe;
    logic serial_clk;
    logic serial_data;
    modport host (
        output interface_select,
        output latch_strobe,
        output attenuation_bits,
        output par_oe,
        output serial_clk,
        output serial_data
    );
    modport dev (
        input interface_select,
        input latch_strobe,
        input attenuation_bits,
        input par_oe,
        input serial_clk,
        input serial_data
    );
endinterface
`default_nettype wire

// ==== logic/sac_device.sv ====
// Purpose: control logic of the 7-bit step attenuator (documented device end)
// Assumes: aclk is the part's internal timebase; aresetn models power-up
// Notes: shift register runs on the link clock, the core state on aclk
`timescale 1ns/100ps
`default_nettype none
module sac_device
    import sac_pkg::*;
#(
    parameter int PUP_CYCLES = SAC_PUP_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    sac_if.dev link,
    input wire logic [2:0] address_pins,
    output logic [6:0] atten_state,
    output logic spare_bit,
    output logic powerup_busy
);
    // ****************************************
    // serial shift register, link clock domain
    // ****************************************
    logic [15:0] shift_stages_q;

    // first bit ends in stage 0 after sixteen shifts; strobe is static while the link clock runs
    always_ff @(posedge link.serial_clk) begin
        if (!link.latch_strobe) begin // R8
            shift_stages_q <= {link.serial_data, shift_stages_q[15:1]}; // R5
        end
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    localparam int SYNC_W = 13;
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;
    logic stb_prev_q;

    assign pins_raw = {address_pins, link.par_oe, link.attenuation_bits,
                       link.latch_strobe, link.interface_select};

    always_ff @(posedge aclk) begin
        meta_q <= pins_raw;
        sync_q <= meta_q;
        stb_prev_q <= sync_q[1];
    end

    // ****************************************
    // decoding
    // ****************************************
    wire sel_s = sync_q[0];
    wire stb_s = sync_q[1];
    wire [6:0] bits_s = sync_q[8:2];
    wire oe_s = sync_q[9];
    wire [2:0] addr_s = sync_q[12:10];
    wire stb_rise = stb_s & ~stb_prev_q;
    // an undriven input is pulled low
    wire [6:0] par_val = oe_s ? bits_s : SAC_ATT_MIN; // R18 R13
    // the register is stable here: the host stopped the clock before raising the strobe
    wire [7:0] att_word = shift_stages_q[7:0]; // R15
    wire [7:0] addr_word = shift_stages_q[15:8]; // R15
    wire addr_match = (addr_word[2:0] == addr_s); // R15
    wire par_follow = ~sel_s & stb_s; // R1 R4
    wire ser_load = sel_s & stb_rise & addr_match; // R1 R6 R8

    // ****************************************
    // power-up and attenuation state
    // ****************************************
    typedef enum logic [2:0] {
        SAC_ST_BOOT = 3'b001,
        SAC_ST_WAIT = 3'b010,
        SAC_ST_RUN = 3'b100
    } sac_dev_st_t;

    sac_dev_st_t state_q;
    sac_dev_st_t state_d;
    logic [17:0] cnt_q;
    logic [17:0] cnt_d;
    logic [6:0] atten_q;
    logic [6:0] atten_d;
    logic spare_q;
    logic spare_d;

    wire boot_done = (cnt_q == 18'(SAC_SYNC_CYCLES - 1));
    wire pup_done = (cnt_q == 18'(PUP_CYCLES - 1));

    // mode is judged once the pins have passed the synchroniser
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + 18'h0_0001;
        atten_d = atten_q;
        spare_d = spare_q;
        case (state_q)
            SAC_ST_BOOT: begin
                if (boot_done) begin
                    cnt_d = 18'h0_0000;
                    state_d = par_follow ? SAC_ST_WAIT : SAC_ST_RUN; // R11 R12
                end
            end
            SAC_ST_WAIT: begin
                if (pup_done) begin
                    cnt_d = 18'h0_0000;
                    atten_d = par_val; // R12 R13
                    state_d = SAC_ST_RUN;
                end
            end
            SAC_ST_RUN: begin
                cnt_d = cnt_q;
                // either path is taken at any time once running
                if (par_follow) begin // R17
                    atten_d = par_val; // R2 R3 R4
                end else if (ser_load) begin
                    atten_d = att_word[6:0]; // R6
                    spare_d = att_word[7];
                end
            end
            default: begin
                state_d = SAC_ST_BOOT;
                cnt_d = 18'h0_0000;
            end
        endcase
    end

    // maximum attenuation from power-up until the first update
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= SAC_ST_BOOT;
            cnt_q <= 18'h0_0000;
            atten_q <= SAC_ATT_MAX; // R11 R12
            spare_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            atten_q <= atten_d;
            spare_q <= spare_d;
        end
    end

    assign atten_state = atten_q;
    assign spare_bit = spare_q;
    assign powerup_busy = (state_q != SAC_ST_RUN);
endmodule
`default_nettype wire

// ==== logic/sac_host.sv ====
// Purpose: host controller driving the attenuator pins, ordered over AXI4-Lite
// Assumes: one outstanding write and one read; link clock derived from aclk
// Notes: writes to PAR or SER while busy get SLVERR and change nothing
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module sac_host
    import sac_pkg::*;
#(
    parameter int HALF = SAC_LINK_HALF,
    parameter int STROBE_HOLD = SAC_STROBE_HOLD
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    sac_if.host link
);
    // ****************************************
    // axi write and read channels
    // ****************************************
    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
    assign s_axi_wready = ~w_hold_q & ~bvalid_q;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire aw_have = aw_hold_q | aw_take;
    wire w_have = w_hold_q | w_take;
    wire [7:0] wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_hold_q ? wdata_q : s_axi_wdata;
    wire wr_fire = aw_have & w_have;
    wire busy;
    wire wr_ctrl = wr_fire & (wr_addr == SAC_REG_CTRL);
    wire wr_par = wr_fire & (wr_addr == SAC_REG_PAR) & ~busy;
    wire wr_ser = wr_fire & (wr_addr == SAC_REG_SER) & ~busy;
    wire wr_ok = wr_ctrl | wr_par | wr_ser | (wr_fire & (wr_addr == SAC_REG_STAT));
    assign s_axi_arready = ~rvalid_q;
    wire ar_take = s_axi_arvalid & s_axi_arready;

    // ****************************************
    // user registers
    // ****************************************
    logic [2:0] ctrl_q;
    logic [6:0] par_q;
    logic [15:0] ser_q;
    logic [31:0] rd_val;
    logic rd_ok;

    assign rd_ok = (s_axi_araddr == SAC_REG_CTRL) | (s_axi_araddr == SAC_REG_PAR) |
                   (s_axi_araddr == SAC_REG_SER) | (s_axi_araddr == SAC_REG_STAT);
    assign rd_val = (s_axi_araddr == SAC_REG_CTRL) ? {29'h0, ctrl_q} :
                    (s_axi_araddr == SAC_REG_PAR) ? {25'h0, par_q} :
                    (s_axi_araddr == SAC_REG_SER) ? {16'h0, ser_q} :
                    (s_axi_araddr == SAC_REG_STAT) ? {31'h0, busy} : 32'h0000_0000;

    // channel holding; the response waits until address and data are both in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            bvalid_q <= 1'b0;
            bresp_q <= SAC_RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= SAC_RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? SAC_RESP_OKAY : SAC_RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_hold_q <= 1'b1;
                    awaddr_q <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_hold_q <= 1'b1;
                    wdata_q <= s_axi_wdata;
                end
                if (bvalid_q && s_axi_bready) begin
                    bvalid_q <= 1'b0;
                end
            end
            if (ar_take) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_val;
                rresp_q <= rd_ok ? SAC_RESP_OKAY : SAC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ****************************************
    // pin sequencer
    // ****************************************
    typedef enum logic [3:0] {
        SAC_HS_IDLE = 4'b0001,
        SAC_HS_SHIFT = 4'b0010,
        SAC_HS_LATCH = 4'b0100,
        SAC_HS_GAP = 4'b1000
    } sac_host_st_t;

    sac_host_st_t hst_q;
    logic [7:0] tick_q;
    logic [4:0] bit_q;
    logic sclk_q;
    logic stb_q;
    logic [15:0] sr_q;

    wire direct = ctrl_q[SAC_CTRL_DIRECT];
    wire tick_end = (tick_q == 8'(HALF - 1));
    wire hold_end = (tick_q == 8'(STROBE_HOLD - 1));
    assign busy = (hst_q != SAC_HS_IDLE);

    // data changes on the falling link edge, the device samples on the rising one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hst_q <= SAC_HS_IDLE;
            tick_q <= 8'h00;
            bit_q <= 5'h00;
            sclk_q <= 1'b0;
            stb_q <= 1'b0;
            sr_q <= 16'h0000;
            ctrl_q <= SAC_CTRL_RST;
            par_q <= 7'h00;
            ser_q <= 16'h0000;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wr_data[2:0];
            end
            case (hst_q)
                SAC_HS_IDLE: begin
                    tick_q <= 8'h00;
                    sclk_q <= 1'b0;
                    stb_q <= 1'b0;
                    if (wr_par) begin
                        par_q <= wr_data[6:0]; // R3
                        hst_q <= SAC_HS_LATCH;
                    end else if (wr_ser) begin
                        ser_q <= wr_data[15:0];
                        sr_q <= wr_data[15:0]; // R7
                        bit_q <= 5'h00;
                        hst_q <= SAC_HS_SHIFT; // R9
                    end
                end
                SAC_HS_SHIFT: begin
                    tick_q <= tick_end ? 8'h00 : tick_q + 8'h01;
                    if (tick_end) begin
                        sclk_q <= ~sclk_q;
                        if (sclk_q) begin
                            sr_q <= {1'b0, sr_q[15:1]}; // R7
                            bit_q <= bit_q + 5'h01;
                            if (bit_q == 5'h0f) begin
                                hst_q <= SAC_HS_LATCH;
                            end
                        end
                    end
                end
                SAC_HS_LATCH: begin
                    stb_q <= 1'b1; // R3 R9
                    tick_q <= hold_end ? 8'h00 : tick_q + 8'h01;
                    if (hold_end) begin
                        hst_q <= SAC_HS_GAP;
                    end
                end
                SAC_HS_GAP: begin
                    stb_q <= 1'b0; // R19
                    tick_q <= hold_end ? 8'h00 : tick_q + 8'h01;
                    if (hold_end) begin
                        hst_q <= SAC_HS_IDLE;
                    end
                end
                default: begin
                    hst_q <= SAC_HS_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // pin drive
    // ****************************************
    assign link.interface_select = ctrl_q[SAC_CTRL_SEL]; // R1
    assign link.latch_strobe = stb_q | (direct & ~ctrl_q[SAC_CTRL_SEL] & ~busy); // R4
    // parallel bits forced low in serial mode
    assign link.attenuation_bits = ctrl_q[SAC_CTRL_SEL] ? 7'h00 : par_q; // R10 R14 R16
    assign link.par_oe = ctrl_q[SAC_CTRL_OE];
    assign link.serial_clk = sclk_q;
    assign link.serial_data = sr_q[0];
endmodule
`default_nettype wire

// ==== test/sac_checker.sv ====
// Purpose: wire and state checks beside the host to device link
// Assumes: one aclk domain; aresetn is the device reset
// Notes: the host made serial clock is sampled on aclk
`timescale 1ns/100ps
`default_nettype none
module sac_checker
    import sac_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic interface_select,
    input wire logic latch_strobe,
    input wire logic [6:0] attenuation_bits,
    input wire logic par_oe,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic [6:0] atten_state,
    input wire logic spare_bit,
    input wire logic powerup_busy
);
    // ****************************************
    // helpers
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // an open parallel pin reads low, so compare against this
    wire logic [6:0] eff_bits = par_oe ? attenuation_bits : 7'h00;
    logic [4:0] bits_seen_q;
    // shift clock rises since the last strobe rise
    always_ff @(posedge aclk) begin
        if (!aresetn || $rose(latch_strobe)) begin
            bits_seen_q <= 5'h00;
        end else if ($rose(serial_clk)) begin
            bits_seen_q <= bits_seen_q + 5'h01;
        end
    end
    sequence s_pulse;
        latch_strobe [*8] ##8 latch_strobe ##1 !latch_strobe;
    endsequence
    sequence s_direct;
        (!interface_select && latch_strobe && !powerup_busy && $stable(eff_bits)) [*5];
    endsequence
    // ****************************************
    // assertions
    // ****************************************
    a_bits_low_serial: assert property (interface_select |-> attenuation_bits == 7'h00)
        else $error("parallel bits driven in serial mode");
    a_shift_strobe_low: assert property ($rose(serial_clk) |-> !latch_strobe)
        else $error("shift clock rose with strobe high");
    a_data_stable_high: assert property (serial_clk |-> $stable(serial_data))
        else $error("serial data moved while shift clock high");
    a_frame_sixteen: assert property ($rose(latch_strobe) && interface_select |-> bits_seen_q == 5'h10)
        else $error("frame length not sixteen bits");
    a_strobe_pulse: assert property ($rose(latch_strobe) && interface_select |-> s_pulse)
        else $error("latch pulse shape wrong");
    a_powerup_max: assert property ($rose(aresetn) |-> atten_state == SAC_ATT_MAX && spare_bit && powerup_busy)
        else $error("power-up state not maximum");
    a_busy_max: assert property (powerup_busy |-> atten_state == SAC_ATT_MAX)
        else $error("state left maximum during power-up");
    a_direct_follow: assert property (s_direct |-> atten_state == eff_bits)
        else $error("direct mode not following parallel bits");
    a_quiet_low: assert property ((!latch_strobe) [*6] |-> $stable(atten_state) && $stable(spare_bit))
        else $error("state changed with strobe low");
endmodule
`default_nettype wire

// ==== test/step_attenuator_control_port_tb.sv ====
// Purpose: drives the host over AXI4-Lite and watches the device state
// Assumes: device power-up delay shortened to 50 cycles
// Notes: the device has its own reset so power-up is repeated mid-run
`timescale 1ns/100ps
`default_nettype none
module step_attenuator_control_port_tb
    import sac_pkg::*;
;
    logic aclk, rstn, dev_rstn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, spare_bit, powerup_busy;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [2:0] addr_pins;
    logic [6:0] atten_state, v, e;
    logic [15:0] frm [4] = '{16'h052a, 16'h0311, 16'hfd95, 16'h050c};
    logic [7:0] fexp [4] = '{8'h2a, 8'h2a, 8'h95, 8'h0c};
    int err_count, n_compared;
    sac_if link_if();
    sac_host sac_host_i (.aclk(aclk), .aresetn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link_if));
    sac_device #(.PUP_CYCLES(50)) sac_device_i (.aclk(aclk), .aresetn(dev_rstn), .link(link_if),
        .address_pins(addr_pins), .atten_state(atten_state), .spare_bit(spare_bit),
        .powerup_busy(powerup_busy));
    sac_checker sac_checker_i (.aclk(aclk), .aresetn(dev_rstn), .interface_select(link_if.interface_select),
        .latch_strobe(link_if.latch_strobe), .attenuation_bits(link_if.attenuation_bits),
        .par_oe(link_if.par_oe), .serial_clk(link_if.serial_clk), .serial_data(link_if.serial_data),
        .atten_state(atten_state), .spare_bit(spare_bit), .powerup_busy(powerup_busy));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // waits whole cycles, then lets the edge updates land
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            aw = aw && awready !== 1'b1;
            w = w && wready !== 1'b1;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    // polling keeps the bench free of any assumed frame length
    task automatic wait_idle();
        do axi_rd(SAC_REG_STAT); while (rd[0] !== 1'b0);
        wait_cyc(8);
    endtask
    task automatic conclude();
        $display("compares %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ****************************************
    // stimulus
    // ****************************************
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // a hang is cut well past the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        $display("watchdog expired");
        conclude();
    end
    initial begin
        {rstn, dev_rstn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {awaddr, araddr, wdata} = 48'h0000_0000_0000;
        wstrb = 4'hf;
        addr_pins = 3'h5;
        err_count = 0;
        n_compared = 0;
        repeat (6) @(posedge aclk);
        rstn <= 1'b1;
        dev_rstn <= 1'b1;
        wait_cyc(10);
        chk(32'({spare_bit, atten_state}), 32'h0000_00ff);
        axi_rd(SAC_REG_CTRL);
        chk(rd, 32'h0000_0000);
        axi_rd(8'h10);
        chk(32'(rs), 32'(SAC_RESP_SLVERR));
        $display("test reset done");
        // serial frames: match, address miss, high address bits, spare cleared
        axi_wr(SAC_REG_CTRL, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            axi_wr(SAC_REG_SER, {16'h0000, frm[i]});
            axi_wr(SAC_REG_PAR, 32'h0000_0001);
            chk(32'(rs), 32'(SAC_RESP_SLVERR));
            wait_idle();
            chk(32'({spare_bit, atten_state}), 32'(fexp[i]));
        end
        $display("test serial done");
        // latched parallel: every weight, then maximum and reference
        axi_wr(SAC_REG_CTRL, 32'h0000_0004);
        for (int i = 0; i < 9; i++) begin
            v = (i < 7) ? 7'h01 << i : ((i == 7) ? SAC_ATT_MAX : SAC_ATT_MIN);
            axi_wr(SAC_REG_PAR, {25'h000_0000, v});
            wait_idle();
            chk(32'(atten_state), 32'(v));
        end
        $display("test latched done");
        // direct mode, driven then open, each followed by a power-up
        axi_wr(SAC_REG_CTRL, 32'h0000_0006);
        axi_wr(SAC_REG_PAR, 32'h0000_0033);
        wait_idle();
        for (int k = 0; k < 2; k++) begin
            e = k ? SAC_ATT_MIN : 7'h33;
            axi_wr(SAC_REG_CTRL, k ? 32'h0000_0002 : 32'h0000_0006);
            wait_cyc(8);
            chk(32'(atten_state), 32'(e));
            @(posedge aclk);
            dev_rstn <= 1'b0;
            wait_cyc(3);
            @(posedge aclk);
            dev_rstn <= 1'b1;
            wait_cyc(40);
            chk(32'({powerup_busy, atten_state}), 32'h0000_00ff);
            wait_cyc(30);
            chk(32'({powerup_busy, atten_state}), 32'(e));
        end
        $display("test direct done");
        conclude();
    end
endmodule
`default_nettype wire
